// file: verification/csfi_card_if_sva.sv
// Concurrent checks on the ports of the card-side function interface.
// Assumes every output is registered one clock after the inputs that cause it.
`timescale 1ns/1ps
module csfi_card_if_sva
   import csfi_pkg::*;
(
   // Inputs of the block
   input  wire logic       i_core_clk,
   input  wire logic       i_nrst,
   input  wire csfi_host_t i_host,
   input  wire csfi_func_t i_func,
   input  wire logic       i_audio_in,
   input  wire logic       i_audio_card,
   input  wire logic [1:0] i_audio_func,
   input  wire logic [1:0] i_func_reset_req,
   input  wire logic       i_lan_mode,
   // Outputs of the block
   input  wire logic       o_card_io_read_n,
   input  wire logic       o_card_io_write_n,
   input  wire logic [1:0] o_func_cs_n,
   input  wire logic       o_byte_high_en_n,
   input  wire logic       o_host_wait_n,
   input  wire logic [1:0] o_function_reset_out,
   input  wire logic       o_ext_attr_mem_select_n,
   input  wire logic       o_speaker_out_n,
   input  wire logic [1:0] o_ready_busy,
   input  wire logic [1:0] o_irq_fwd,
   input  wire logic       o_lan_packet
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic idle;
   assign idle = &o_func_cs_n;
   a_read_strobe: assert property ($past(i_nrst) |-> o_card_io_read_n ==
      (idle | $past(i_host.io_read_n | i_host.reg_n | (i_host.ce1_n & i_host.ce2_n))))
      else $error("read strobe wrong");
   a_write_strobe: assert property ($past(i_nrst) |-> o_card_io_write_n ==
      (idle | $past(i_host.io_write_n | i_host.reg_n | (i_host.ce1_n & i_host.ce2_n))))
      else $error("write strobe wrong");
   a_width_select: assert property (!idle |->
      o_byte_high_en_n == $past(i_host.ce1_n | i_host.ce2_n)) else $error("byte high enable wrong");
   a_single_select: assert property ($onehot0(~o_func_cs_n))
      else $error("two functions selected");
   a_reset_holds_cs: assert property ((o_function_reset_out & ~o_func_cs_n) == 2'b00)
      else $error("select during function reset");
   a_func_reset: assert property ($past(i_nrst) && !$past(i_lan_mode) |->
      o_function_reset_out == $past(i_func_reset_req)) else $error("function reset wrong");
   a_status_copy: assert property ($past(i_nrst) |->
      {o_ready_busy, o_irq_fwd} == $past({i_func.ready, i_func.irq_in})) else $error("status copy wrong");
   a_wait_pass: assert property ($past(i_nrst) |->
      o_host_wait_n == !(|($past(i_func.wait_in) & ~o_func_cs_n))) else $error("host wait wrong");
   a_speaker_mix: assert property ($past(i_nrst) |->
      o_speaker_out_n == !$past(i_audio_card && (|i_audio_func) && i_audio_in)) else $error("speaker wrong");
   a_ext_attr: assert property ($past(i_nrst) |-> o_ext_attr_mem_select_n ==
      !$past(!i_host.reg_n && !(i_host.oe_n && i_host.we_n) && i_host.addr >= CSFI_ATTR_LIMIT))
      else $error("attr select wrong");
   a_lan_packet: assert property ($past(i_nrst) |->
      o_lan_packet == $past(i_lan_mode && !i_func.ring_in0_n)) else $error("packet flag wrong");
   c_wide_read: cover property (!o_card_io_read_n && !o_byte_high_en_n);
   c_wait: cover property (!o_host_wait_n);
   c_attr: cover property (!o_ext_attr_mem_select_n);
endmodule
bind csfi_card_if csfi_card_if_sva u_sva (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_host(i_host),
   .i_func(i_func), .i_audio_in(i_audio_in), .i_audio_card(i_audio_card), .i_audio_func(i_audio_func),
   .i_func_reset_req(i_func_reset_req), .i_lan_mode(i_lan_mode), .o_card_io_read_n(o_card_io_read_n),
   .o_card_io_write_n(o_card_io_write_n), .o_func_cs_n(o_func_cs_n), .o_byte_high_en_n(o_byte_high_en_n),
   .o_host_wait_n(o_host_wait_n), .o_function_reset_out(o_function_reset_out),
   .o_ext_attr_mem_select_n(o_ext_attr_mem_select_n), .o_speaker_out_n(o_speaker_out_n),
   .o_ready_busy(o_ready_busy), .o_irq_fwd(o_irq_fwd), .o_lan_packet(o_lan_packet));

// file: verification/csfi_card_if_tb_top.sv
// Self-checking bench for the card-side function interface.
// Assumes the function model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module csfi_card_if_tb_top
   import csfi_pkg::*;
;
   logic clk, nrst, lan, acard, audio, wait_n, wide_n, rd_n, wr_n, bhe_n, ext_n, spk, pkt;
   logic [1:0] win_en, rst_req, afunc, wide_en, ready, irq, ring_n, cs_n, fro, rdy, irqf, ring;
   logic [3:0] pdir, pwr, gpin, wait_len, gpout, gpoe, gprd;
   logic [15:0] hdata, hdata_o, win0, win1, ldata, lbus, loe;
   csfi_host_t host;
   csfi_func_t func;
   int n_mismatch, cmp_count, cyc;
   csfi_card_if DUT (.i_core_clk(clk), .i_nrst(nrst), .i_host(host), .i_host_data(hdata),
      .o_host_data(hdata_o), .o_host_wait_n(wait_n), .o_host_wide_n(wide_n), .i_win0_base(win0),
      .i_win1_base(win1), .i_win_enable(win_en), .i_func_reset_req(rst_req), .i_lan_mode(lan),
      .i_port_dir(pdir), .i_port_wr_data(pwr), .i_audio_card(acard), .i_audio_func(afunc),
      .i_func(func), .i_audio_in(audio), .i_local_data_bus_in(ldata), .o_local_data_bus_out(lbus),
      .o_local_data_bus_oe(loe), .o_card_io_read_n(rd_n), .o_card_io_write_n(wr_n), .o_func_cs_n(cs_n),
      .o_byte_high_en_n(bhe_n), .o_function_reset_out(fro), .o_ext_attr_mem_select_n(ext_n),
      .o_speaker_out_n(spk), .o_ready_busy(rdy), .o_irq_fwd(irqf), .o_ring_fwd(ring), .o_lan_packet(pkt),
      .i_general_purpose_port_in(gpin), .o_general_purpose_port_out(gpout),
      .o_general_purpose_port_oe(gpoe), .o_port_rd_data(gprd));
   csfi_func_model u_func (.i_core_clk(clk), .i_nrst(nrst), .i_func_cs_n(cs_n), .i_rd_n(rd_n),
      .i_wait_len(wait_len), .i_wide_en(wide_en), .i_ready(ready), .i_irq(irq), .i_ring_n(ring_n),
      .o_data(ldata), .o_func(func));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic conclude;
      $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Three edges: select, model answers, interface captures the answer.
   task automatic acc(input logic [15:0] a, input logic rd, wr, oe, rg, c1, c2);
      @(posedge clk);
      host <= '{a, rd, wr, oe, 1'b1, rg, c1, c2};
      tick(3);
   endtask
   task automatic t_read;
      acc(16'h0305, 0, 1, 1, 0, 0, 0);
      chk(16'(cs_n), 16'h0002);
      chk(16'(rd_n), 16'h0000);
      chk(16'(bhe_n), 16'h0000);
      chk(hdata_o, 16'h5a3c);
      chk(loe, 16'h0000);
      acc(16'h0304, 0, 1, 1, 0, 0, 1);
      chk(16'(bhe_n), 16'h0001);
      chk(16'(hdata_o[7:0]), 16'h003c);
      acc(16'h0305, 0, 1, 1, 0, 1, 0);
      chk(16'(hdata_o[15:8]), 16'h003c);
      acc(16'h0305, 0, 1, 1, 1, 0, 0);
      chk(16'(rd_n), 16'h0001);
      acc(16'h0305, 0, 1, 1, 0, 1, 1);
      chk(16'(rd_n), 16'h0001);
   endtask
   task automatic t_write;
      acc(16'h02fa, 1, 0, 1, 0, 0, 1);
      chk(16'({cs_n, wr_n}), 16'h0002);
      chk(16'(lbus[7:0]), 16'h00ef);
      chk(loe, 16'h00ff);
      acc(16'h02fb, 1, 0, 1, 0, 1, 0);
      chk(16'(lbus[7:0]), 16'h00be);
      acc(16'h02fa, 1, 0, 1, 0, 0, 0);
      chk(lbus, 16'hbeef);
      chk(loe, 16'hffff);
      acc(16'h02fa, 1, 0, 1, 1, 0, 0);
      chk(16'(wr_n), 16'h0001);
   endtask
   task automatic t_decode;
      acc(16'h0400, 0, 1, 1, 0, 0, 0);
      chk(16'({cs_n, rd_n}), 16'h0007);
      win_en <= 2'b10;
      acc(16'h0305, 0, 1, 1, 0, 0, 0);
      chk(16'({cs_n, rd_n}), 16'h0007);
      win_en <= 2'b11;
      win1   <= 16'h0300;
      acc(16'h0301, 0, 1, 1, 0, 0, 0);
      chk(16'(cs_n), 16'h0002);
      win1 <= 16'h02f8;
   endtask
   task automatic t_wait;
      int lows;
      lows     = 0;
      wait_len <= 4'h3;
      wide_en  <= 2'b01;
      acc(16'h0000, 1, 1, 1, 1, 1, 1);
      @(posedge clk);
      host <= '{16'h0302, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      repeat (12)
      begin
         tick(1);
         lows += int'(wait_n === 1'b0);
      end
      chk(16'(lows), 16'h0003);
      chk(16'(wide_n), 16'h0000);
      wait_len <= 4'h0;
      wide_en  <= 2'b00;
      tick(3);
      chk(16'({wait_n, wide_n}), 16'h0003);
   endtask
   task automatic t_func_reset;
      rst_req <= 2'b01;
      acc(16'h0305, 0, 1, 1, 0, 0, 0);
      chk(16'(fro), 16'h0001);
      chk(16'({cs_n, rd_n}), 16'h0007);
      rst_req <= 2'b00;
      tick(2);
   endtask
   task automatic t_host_reset;
      acc(16'h0305, 0, 1, 1, 0, 0, 0);
      nrst <= 1'b0;
      tick(1);
      chk(16'({cs_n, rd_n, fro}), 16'h001f);
      nrst <= 1'b1;
      tick(2);
      chk(16'({cs_n, rd_n}), 16'h0004);
   endtask
   task automatic t_status;
      ready  <= 2'b01;
      irq    <= 2'b01;
      ring_n <= 2'b01;
      pdir   <= 4'b0101;
      pwr    <= 4'b1111;
      gpin   <= 4'b1010;
      tick(3);
      chk(16'({rdy, irqf, ring}), 16'h0016);
      chk(16'({gpoe, gpout & pdir}), 16'h0055);
      chk(16'(gprd & ~pdir), 16'h000a);
      lan    <= 1'b1;
      ring_n <= 2'b10;
      gpin   <= 4'b0000;
      tick(3);
      chk(16'({pkt, ring[0]}), 16'h0002);
      chk(16'(gpout[1:0]), 16'h0003);
      lan <= 1'b0;
      tick(2);
   endtask
   task automatic t_misc;
      for (int i = 0; i < 16; i++)
      begin
         {acard, afunc, audio} <= 4'(i);
         tick(2);
         chk(16'(spk), 16'(!(i[3] && (|i[2:1]) && i[0])));
      end
      acc(16'h0800, 1, 1, 0, 0, 0, 1);
      chk(16'(ext_n), 16'h0000);
      acc(16'h07fe, 1, 1, 0, 0, 0, 1);
      chk(16'(ext_n), 16'h0001);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         conclude;
      end
   end
   initial
   begin
      {nrst, lan, acard, audio, afunc, rst_req, wide_en, wait_len, pdir, pwr, gpin} = '0;
      host   = '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      hdata  = 16'hbeef;
      win0   = CSFI_WIN0_BASE;
      win1   = CSFI_WIN1_BASE;
      win_en = 2'b11;
      ready  = 2'b11;
      irq    = 2'b00;
      ring_n = 2'b11;
      tick(16);
      chk(16'({cs_n, rd_n, wr_n, fro, spk}), 16'h007f);
      nrst <= 1'b1;
      t_read;
      t_write;
      t_decode;
      t_wait;
      t_func_reset;
      t_host_reset;
      t_status;
      t_misc;
      conclude;
   end
endmodule

// file: verification/csfi_func_model.sv
// Behavioural model of the two card functions on the local bus.
// Assumes selects and strobes arrive registered from the interface.
`timescale 1ns/1ps
module csfi_func_model
   import csfi_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // From the interface
   input  wire logic [1:0]  i_func_cs_n,
   input  wire logic        i_rd_n,
   // Behaviour set by the bench
   input  wire logic [3:0]  i_wait_len,
   input  wire logic [1:0]  i_wide_en,
   input  wire logic [1:0]  i_ready,
   input  wire logic [1:0]  i_irq,
   input  wire logic [1:0]  i_ring_n,
   // Toward the interface
   output      logic [15:0] o_data,
   output      csfi_func_t  o_func
);
   logic [3:0] wait_cnt_reg;
   logic [1:0] sel;
   assign sel = ~i_func_cs_n;
   // Unselected, the bus toggles so a stale value can never pass for read data.
   always_ff @(posedge i_core_clk or negedge i_nrst)
      if (!i_nrst)
      begin
         wait_cnt_reg <= 4'h0;
         o_data       <= 16'h0000;
      end
      else
      begin
         wait_cnt_reg <= (sel == 2'b00) ? 4'h0 : wait_cnt_reg + 4'((wait_cnt_reg < i_wait_len));
         o_data       <= (sel != 2'b00 && !i_rd_n) ? (sel[0] ? 16'h5a3c : 16'hc3a5) : ~o_data;
      end
   always_comb
   begin
      o_func.wait_in        = (wait_cnt_reg < i_wait_len) ? sel : 2'b00;
      o_func.wide_capable_n = ~(sel & i_wide_en);
      o_func.ready          = i_ready;
      o_func.irq_in         = i_irq;
      o_func.ring_in0_n     = i_ring_n[0];
      o_func.ring_in1_n     = i_ring_n[1];
   end
endmodule

// file: verilog/csfi_card_if.sv
// Card-side function interface: host I/O strobes to two ISA-like card functions.
// Assumes all inputs synchronous to i_core_clk; host reset arrives on i_nrst.
//
// What this block does
// RULE_01: Card read strobe is host read OR REG OR both card enables high.
// RULE_02: Card write strobe is host write OR REG OR both card enables high.
// RULE_03: Chip select with byte high enable off carries eight bits on low lane.
// RULE_04: Single bytes always travel on the low lane, odd or even address.
// RULE_05: Chip select with byte high enable on carries sixteen bits on full bus.
// RULE_06: One active-low chip select per function; only the addressed one asserts.
// RULE_07: Each function ready input shows as its ready/busy status; low is busy.
// RULE_08: Each function has a wait input that stretches the current card transaction.
// RULE_09: Each function gets its own reset output.
// RULE_10: Four-bit general purpose port with per-bit programmable direction.
// RULE_11: LAN mode gives general purpose port bits fixed network controller roles.
// RULE_12: Attribute accesses outside the shadowed region select external attribute memory.
// RULE_13: Ring inputs per function; in LAN mode function 0 ring is packet indicator.
// RULE_14: Each function interrupt input is forwarded toward host interrupt logic.
// RULE_15: Host wait output inserts wait states while a function holds its wait.
// RULE_16: A function asserts its wide-capable input; block drives host 16-bit indication.
// RULE_17: Speaker output is inverted audio when audio bits set, otherwise high.
// RULE_18: Host address is decoded against each function window; never two selected.
// RULE_19: Function in reset, or host reset, keeps its select and strobes idle.
`timescale 1ns/1ps
module csfi_card_if
   import csfi_pkg::*;
#(
   parameter int          NUM_FUNC = CSFI_NUM_FUNC,
   parameter int          PORT_W   = CSFI_PORT_W
)
(
   // Clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_nrst,
   // Host side
   input  wire csfi_host_t          i_host,
   input  wire logic [15:0]         i_host_data,
   output      logic [15:0]         o_host_data,
   output      logic                o_host_wait_n,
   output      logic                o_host_wide_n,
   // Configuration
   input  wire logic [15:0]         i_win0_base,
   input  wire logic [15:0]         i_win1_base,
   input  wire logic [1:0]          i_win_enable,
   input  wire logic [1:0]          i_func_reset_req,
   input  wire logic                i_lan_mode,
   input  wire logic [PORT_W-1:0]   i_port_dir,
   input  wire logic [PORT_W-1:0]   i_port_wr_data,
   input  wire logic                i_audio_card,
   input  wire logic [1:0]          i_audio_func,
   // Card functions
   input  wire csfi_func_t          i_func,
   input  wire logic                i_audio_in,
   input  wire logic [15:0]         i_local_data_bus_in,
   output      logic [15:0]         o_local_data_bus_out,
   output      logic [15:0]         o_local_data_bus_oe,
   output      logic                o_card_io_read_n,
   output      logic                o_card_io_write_n,
   output      logic [1:0]          o_func_cs_n,
   output      logic                o_byte_high_en_n,
   output      logic [1:0]          o_function_reset_out,
   output      logic                o_ext_attr_mem_select_n,
   output      logic                o_speaker_out_n,
   // Status toward host logic
   output      logic [1:0]          o_ready_busy,
   output      logic [1:0]          o_irq_fwd,
   output      logic [1:0]          o_ring_fwd,
   output      logic                o_lan_packet,
   // General purpose port
   input  wire logic [PORT_W-1:0]   i_general_purpose_port_in,
   output      logic [PORT_W-1:0]   o_general_purpose_port_out,
   output      logic [PORT_W-1:0]   o_general_purpose_port_oe,
   output      logic [PORT_W-1:0]   o_port_rd_data
);

   // Refused at elaboration: the lane and port packing below is fixed.
   if (NUM_FUNC != 2)
      $error("csfi_card_if serves exactly two functions");
   if (PORT_W != 4)
      $error("csfi_card_if general purpose port must be four bits");

   // ****************************************************************
   // Address decode
   // ****************************************************************
   logic [1:0] win_hit;
   logic [1:0] sel;
   logic       strobe_ok;
   logic       rd_raw_n;
   logic       wr_raw_n;
   logic       wide_req;
   logic [1:0] reset_next;
   csfi_state_t state_reg;
   csfi_state_t state_next;

   csfi_win_dec u_win0
   (
      .i_addr (i_host.addr),
      .i_base (i_win0_base),
      .i_mask (CSFI_WIN_MASK),
      .o_hit  (win_hit[0])
   );

   csfi_win_dec u_win1
   (
      .i_addr (i_host.addr),
      .i_base (i_win1_base),
      .i_mask (CSFI_WIN_MASK),
      .o_hit  (win_hit[1])
   );

   // Selects look at the reset about to be driven, so a select never overlaps a function reset.
   assign reset_next = i_func_reset_req
                       | (i_lan_mode ? {1'b0, i_general_purpose_port_in[CSFI_LAN_RST]} : 2'b00);

   // Function 0 wins an overlap so at most one select can ever assert.
   always_comb
   begin
      sel = 2'b00;
      if (win_hit[0] && i_win_enable[0] && !reset_next[0])          // see RULE_18, RULE_19
         sel = 2'b01;
      else if (win_hit[1] && i_win_enable[1] && !reset_next[1])     // see RULE_18, RULE_19
         sel = 2'b10;
   end

   assign strobe_ok = (sel != 2'b00);
   assign rd_raw_n  = i_host.io_read_n | i_host.reg_n | (i_host.ce1_n & i_host.ce2_n);   // see RULE_01
   assign wr_raw_n  = i_host.io_write_n | i_host.reg_n | (i_host.ce1_n & i_host.ce2_n);  // see RULE_02
   // A 16-bit cycle needs both card enables low.
   assign wide_req  = !i_host.ce1_n && !i_host.ce2_n;

   // ****************************************************************
   // Transaction sequencing
   // ****************************************************************
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         CSFI_IDLE:
            if (strobe_ok && !(rd_raw_n && wr_raw_n))
               state_next = CSFI_ACCESS;
         CSFI_ACCESS:
            if (|(i_func.wait_in & sel))                                 // see RULE_08
               state_next = CSFI_STRETCH;
            else if (rd_raw_n && wr_raw_n)
               state_next = CSFI_IDLE;
         CSFI_STRETCH:
            if (!(|(i_func.wait_in & sel)))
               state_next = (rd_raw_n && wr_raw_n) ? CSFI_IDLE : CSFI_ACCESS;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         state_reg <= CSFI_IDLE;
      else
         state_reg <= state_next;
   end

   // ****************************************************************
   // Card strobes, selects and byte lanes
   // ****************************************************************
   // Asynchronous reset forces every select and strobe idle.
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_func_cs_n       <= 2'b11;                                     // see RULE_19
         o_card_io_read_n  <= CSFI_HIGH;
         o_card_io_write_n <= CSFI_HIGH;
         o_byte_high_en_n  <= CSFI_HIGH;
      end
      else
      begin
         o_func_cs_n       <= ~sel;                                      // see RULE_06
         o_card_io_read_n  <= rd_raw_n | !strobe_ok;                     // see RULE_01
         o_card_io_write_n <= wr_raw_n | !strobe_ok;                     // see RULE_02
         o_byte_high_en_n  <= !(strobe_ok && wide_req);                  // see RULE_03, RULE_05
      end
   end

   // Single bytes are steered to the low lane whatever the address parity.
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_local_data_bus_out <= 16'h0000;
         o_local_data_bus_oe  <= 16'h0000;
         o_host_data          <= 16'h0000;
      end
      else if (strobe_ok && wide_req)
      begin
         o_local_data_bus_out <= i_host_data;                            // see RULE_05
         o_local_data_bus_oe  <= {16{!wr_raw_n}};
         o_host_data          <= i_local_data_bus_in;
      end
      else
      begin
         o_local_data_bus_out <= {8'h00, i_host.ce1_n ? i_host_data[15:8] : i_host_data[7:0]};  // see RULE_04
         o_local_data_bus_oe  <= {8'h00, {8{strobe_ok && !wr_raw_n}}};   // see RULE_03
         o_host_data          <= i_host.ce1_n ? {i_local_data_bus_in[7:0], 8'h00}
                                              : {8'h00, i_local_data_bus_in[7:0]};
      end
   end

   // ****************************************************************
   // Host wait, wide indication and attribute memory select
   // ****************************************************************
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_host_wait_n           <= CSFI_HIGH;
         o_host_wide_n           <= CSFI_HIGH;
         o_ext_attr_mem_select_n <= CSFI_HIGH;
      end
      else
      begin
         o_host_wait_n           <= !(|(i_func.wait_in & sel));          // see RULE_15, RULE_08
         o_host_wide_n           <= !(|(~i_func.wide_capable_n & sel));  // see RULE_16
         o_ext_attr_mem_select_n <= !(!i_host.reg_n && !(i_host.oe_n && i_host.we_n)
                                    && (i_host.addr >= CSFI_ATTR_LIMIT)); // see RULE_12
      end
   end

   // ****************************************************************
   // Function resets, status and forwarding
   // ****************************************************************
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_function_reset_out <= 2'b11;                                  // see RULE_09
      else
         o_function_reset_out <= reset_next;                             // see RULE_09
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_ready_busy <= 2'b00;
         o_irq_fwd    <= 2'b00;
         o_ring_fwd   <= 2'b00;
         o_lan_packet <= CSFI_LOW;
      end
      else
      begin
         o_ready_busy <= i_func.ready;                                   // see RULE_07
         o_irq_fwd    <= i_func.irq_in;                                  // see RULE_14
         o_ring_fwd   <= {!i_func.ring_in1_n, !i_func.ring_in0_n && !i_lan_mode};  // see RULE_13
         o_lan_packet <= i_lan_mode && !i_func.ring_in0_n;               // see RULE_13
      end
   end

   // ****************************************************************
   // Speaker
   // ****************************************************************
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_speaker_out_n <= CSFI_HIGH;
      else
         o_speaker_out_n <= (i_audio_card && |i_audio_func) ? !i_audio_in : CSFI_HIGH;  // see RULE_17
   end

   // ****************************************************************
   // General purpose port
   // ****************************************************************
   // In LAN mode bit roles are fixed: packet, interrupt and ready are
   // driven out, bit 3 becomes a reset request input from the controller.
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_general_purpose_port_out <= CSFI_PORT_RST;
         o_general_purpose_port_oe  <= CSFI_PORT_RST;
         o_port_rd_data             <= CSFI_PORT_RST;
      end
      else if (i_lan_mode)
      begin
         o_general_purpose_port_out <= {1'b0, i_func.ready[0], i_func.irq_in[0], !i_func.ring_in0_n};  // see RULE_11
         o_general_purpose_port_oe  <= CSFI_LAN_DIR & ~(4'h1 << CSFI_LAN_RST);                         // see RULE_11
         o_port_rd_data             <= i_general_purpose_port_in;
      end
      else
      begin
         o_general_purpose_port_out <= i_port_wr_data;                   // see RULE_10
         o_general_purpose_port_oe  <= i_port_dir;                       // see RULE_10
         o_port_rd_data             <= (i_port_wr_data & i_port_dir) | (i_general_purpose_port_in & ~i_port_dir);
      end
   end

endmodule

// file: verilog/csfi_pkg.sv
// Package for the card-side function interface: shared constants and carrier structs.
// Assumes a single 50 MHz core clock domain.
package csfi_pkg;

   localparam int          CSFI_NUM_FUNC   = 2;
   localparam int          CSFI_ADDR_W     = 16;
   localparam int          CSFI_DATA_W     = 16;
   localparam int          CSFI_PORT_W     = 4;
   localparam int          CSFI_BYTE_W     = 8;

   // Default function I/O windows (base, mask of decoded bits).
   localparam logic [15:0] CSFI_WIN0_BASE  = 16'h0300;
   localparam logic [15:0] CSFI_WIN1_BASE  = 16'h02f8;
   localparam logic [15:0] CSFI_WIN_MASK   = 16'hfff0;

   // Attribute space shadowed on chip: addresses below this limit.
   localparam logic [15:0] CSFI_ATTR_LIMIT = 16'h0800;

   // Reset values.
   localparam logic [3:0]  CSFI_PORT_RST   = 4'h0;
   localparam logic        CSFI_HIGH       = 1'b1;
   localparam logic        CSFI_LOW        = 1'b0;

   // LAN mode roles of the general purpose port bits.
   localparam int          CSFI_LAN_PKT    = 0;
   localparam int          CSFI_LAN_IRQ    = 1;
   localparam int          CSFI_LAN_RDY    = 2;
   localparam int          CSFI_LAN_RST    = 3;
   localparam logic [3:0]  CSFI_LAN_DIR    = 4'hf;

   typedef struct packed {
      logic [15:0] addr;
      logic        io_read_n;
      logic        io_write_n;
      logic        oe_n;
      logic        we_n;
      logic        reg_n;
      logic        ce1_n;
      logic        ce2_n;
   } csfi_host_t;

   typedef struct packed {
      logic [1:0]  wait_in;
      logic [1:0]  wide_capable_n;
      logic [1:0]  ready;
      logic [1:0]  irq_in;
      logic        ring_in0_n;
      logic        ring_in1_n;
   } csfi_func_t;

   typedef enum logic [1:0] {CSFI_IDLE, CSFI_ACCESS, CSFI_STRETCH} csfi_state_t;

endpackage

// file: verilog/csfi_win_dec.sv
// One function's I/O window comparator.
// Assumes base and mask are stable configuration inputs.
`timescale 1ns/1ps
module csfi_win_dec
   import csfi_pkg::*;
#(
   parameter int ADDR_W = CSFI_ADDR_W
)
(
   // Address and window
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [ADDR_W-1:0] i_base,
   input  wire logic [ADDR_W-1:0] i_mask,
   // Result
   output      logic              o_hit
);

   assign o_hit = ((i_addr & i_mask) == (i_base & i_mask));

endmodule
